// ### rtl/ccs_regs.svh
`ifndef CCS_REGS_SVH
`define CCS_REGS_SVH

// Clock rate and time base.
`define CCS_CLK_MHZ 50
`define CCS_MS_PER_SEC 1000

// Deglitch times.
`define CCS_OV_ENTER_US 100
`define CCS_OV_EXIT_MS 12
`define CCS_UV_ENTER_US 100
`define CCS_UV_EXIT_MS 12
`define CCS_TERM_MS 220
`define CCS_RECHG_MS 200
`define CCS_TS_MS 25

// Alert pulse width on a status change.
`define CCS_ALERT_US 256

// Safety, tracking and watchdog timers, in seconds, and the input disconnect default.
`define CCS_PRECHG_SEC 16'h1c20
`define CCS_FAST_DEF_SEC 16'h7080
`define CCS_TOPOFF_DEF_SEC 16'h0708
`define CCS_CV_DEF_SEC 16'h8ca0
`define CCS_PO_DEF_SEC 16'h0001
`define CCS_SCAN_DEF_SEC 16'h0258
`define CCS_WDOG_DEF_SEC 16'h00a0
`define CCS_HIZ_DEF 1'h0

// Thermistor zone code that suspends charging.
`define CCS_TS_FAULT_ZONE 2'h3

`endif

// ### rtl/ccs_pkg.sv
package ccs_pkg;

	typedef enum logic [2:0] {
		CCS_IDLE = 3'b000,
		CCS_TRICKLE = 3'b001,
		CCS_PRECHG = 3'b010,
		CCS_CC = 3'b011,
		CCS_CV = 3'b100,
		CCS_TOPOFF = 3'b101,
		CCS_DONE = 3'b110,
		CCS_FAULT = 3'b111
	} ccs_phase_type;

	typedef struct packed {
		logic [15:0] fast_charge_timer_setting;
		logic [15:0] finish_phase_timer_setting;
		logic [15:0] voltage_phase_timer_setting;
		logic [15:0] perturb_observe_interval;
		logic [15:0] panel_scan_interval;
		logic [15:0] watchdog_setting;
		logic input_disconnect_enable;
	} ccs_settings_type;

	typedef struct packed {
		ccs_phase_type phase;
		logic input_overvoltage;
		logic input_undervoltage;
		logic [1:0] thermistor_zone;
		logic timer_fault;
		logic watchdog_fault;
	} ccs_status_type;

endpackage

// ### rtl/ccs_top.sv
`timescale 1ns/1ps
`include "ccs_regs.svh"

// Function
// - Overvoltage entered after 100 us steady assertion.
// - Overvoltage left after 12 ms steady deassertion.
// - Undervoltage entered after 100 us steady low.
// - Undervoltage left after 12 ms above threshold.
// - Termination acted on after 220 ms persistence.
// - Recharge acted on after 200 ms persistence.
// - Pre-charge phase limited to two hours.
// - Fast charge limited by programmable safety timer.
// - Programmable top-off timer runs after termination.
// - Constant-voltage phase limited by programmable timer.
// - Thermistor crossing accepted after 25 ms hold.
// - Perturb-and-observe step on programmable interval.
// - Full panel sweep on programmable interval.
// - Watchdog fires after programmable time, 160 s by default.
// - Watchdog expiry restores default settings.
// - Phases advance trickle, pre-charge, CC, CV.
// - CV phase ends on low charge current.
// - Full battery below recharge starts new cycle.
// - Input outside window halts charge, power-good released.
// - Alert pulses on every status change.
// - Host may drive status pins directly.
// - Valid input inside window drives power-good low.
module ccs_top #(
	parameter int OV_ENTER_CYC = `CCS_OV_ENTER_US * `CCS_CLK_MHZ,
	parameter int OV_EXIT_CYC = `CCS_OV_EXIT_MS * `CCS_CLK_MHZ * 1000,
	parameter int UV_ENTER_CYC = `CCS_UV_ENTER_US * `CCS_CLK_MHZ,
	parameter int UV_EXIT_CYC = `CCS_UV_EXIT_MS * `CCS_CLK_MHZ * 1000,
	parameter int TERM_CYC = `CCS_TERM_MS * `CCS_CLK_MHZ * 1000,
	parameter int RECHG_CYC = `CCS_RECHG_MS * `CCS_CLK_MHZ * 1000,
	parameter int TS_CYC = `CCS_TS_MS * `CCS_CLK_MHZ * 1000,
	parameter int MS_TICK_CYC = `CCS_CLK_MHZ * 1000,
	parameter int ALERT_CYC = `CCS_ALERT_US * `CCS_CLK_MHZ
) (
	// Clock and reset.
	input wire logic clk_i,
	input wire logic reset_n_i,
	// Analog comparator results.
	input wire logic input_voltage_present_i,
	input wire logic input_overvoltage_sense_i,
	input wire logic input_undervoltage_sense_i,
	input wire logic charge_current_low_i,
	input wire logic feedback_voltage_low_i,
	input wire logic [1:0] thermistor_sense_i,
	input wire logic battery_above_short_i,
	input wire logic battery_above_low_i,
	input wire logic battery_at_regulation_i,
	// Charge enable pin.
	input wire logic charge_enable_n_i,
	// Host side.
	input wire logic host_access_i,
	input wire logic settings_write_i,
	input wire ccs_pkg::ccs_settings_type settings_i,
	input wire logic indicator_override_i,
	input wire logic [2:0] indicator_level_i,
	input wire logic power_point_tracking_enable_i,
	// Pins and status.
	output logic power_good_out_n_o,
	output logic charge_status_pin_a_n_o,
	output logic charge_status_pin_b_n_o,
	output logic host_alert_n_o,
	output logic charger_enable_o,
	output logic perturb_step_o,
	output logic panel_scan_o,
	output ccs_pkg::ccs_status_type status_o,
	output ccs_pkg::ccs_settings_type settings_o
);

	localparam ccs_pkg::ccs_settings_type SETTINGS_DEFAULT = '{
		fast_charge_timer_setting: `CCS_FAST_DEF_SEC,
		finish_phase_timer_setting: `CCS_TOPOFF_DEF_SEC,
		voltage_phase_timer_setting: `CCS_CV_DEF_SEC,
		perturb_observe_interval: `CCS_PO_DEF_SEC,
		panel_scan_interval: `CCS_SCAN_DEF_SEC,
		watchdog_setting: `CCS_WDOG_DEF_SEC,
		input_disconnect_enable: `CCS_HIZ_DEF
	};
	localparam logic [3:0][23:0] ENTER_LIM = {
		24'(RECHG_CYC - 1), 24'(TERM_CYC - 1),
		24'(UV_ENTER_CYC - 1), 24'(OV_ENTER_CYC - 1)
	};
	localparam logic [3:0][23:0] EXIT_LIM = {
		24'h0, 24'h0, 24'(UV_EXIT_CYC - 1), 24'(OV_EXIT_CYC - 1)
	};

	// Interval counter expiry; a zero setting disables the interval.
	function automatic logic reached(input logic [15:0] count,
		input logic [15:0] limit);
		reached = (limit != 16'h0) && (count >= limit);
	endfunction

	logic reset_meta_n;
	logic rst_n;
	logic [15:0] ms_cnt;
	logic [9:0] sec_cnt;
	logic ms_tick;
	logic sec_tick;
	logic [3:0] dgl;
	logic [1:0] ts_zone;
	logic [1:0] ts_cand;
	logic [23:0] ts_cnt;
	ccs_pkg::ccs_phase_type phase;
	ccs_pkg::ccs_phase_type next_phase;
	logic [15:0] phase_sec;
	logic [15:0] fast_sec;
	logic [15:0] wd_sec;
	logic [15:0] po_sec;
	logic [15:0] scan_sec;
	logic timer_fault;
	logic wd_fault;
	ccs_pkg::ccs_settings_type settings;
	ccs_pkg::ccs_status_type status_prev;
	logic [23:0] alert_cnt;

	// Release of the asynchronous reset through two flip-flops.
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			reset_meta_n <= 1'h0;
			rst_n <= 1'h0;
		end else begin
			reset_meta_n <= 1'h1;
			rst_n <= reset_meta_n;
		end
	end

	// Millisecond and second enables.
	assign ms_tick = (ms_cnt == 16'(MS_TICK_CYC - 1));
	assign sec_tick = ms_tick && (sec_cnt == 10'(`CCS_MS_PER_SEC - 1));

	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			ms_cnt <= 16'h0;
			sec_cnt <= 10'h0;
		end else begin
			ms_cnt <= ms_tick ? 16'h0 : ms_cnt + 16'h1;
			if (sec_tick) begin
				sec_cnt <= 10'h0;
			end else if (ms_tick) begin
				sec_cnt <= sec_cnt + 10'h1;
			end
		end
	end

	// Comparator deglitch: bit 0 overvoltage, 1 undervoltage,
	// 2 termination current, 3 recharge level.
	wire [3:0] dgl_raw = {feedback_voltage_low_i, charge_current_low_i,
		input_undervoltage_sense_i, input_overvoltage_sense_i};

	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++) begin : g_dgl
			logic filt;
			logic [23:0] cnt;
			wire [23:0] lim = filt ? EXIT_LIM[gi] : ENTER_LIM[gi];
			always_ff @(posedge clk_i or negedge rst_n) begin
				if (!rst_n) begin
					filt <= 1'h0;
					cnt <= 24'h0;
				end else if (dgl_raw[gi] == filt) begin
					cnt <= 24'h0;
				end else if (cnt >= lim) begin
					filt <= dgl_raw[gi];
					cnt <= 24'h0;
				end else begin
					cnt <= cnt + 24'h1;
				end
			end
			assign dgl[gi] = filt;
		end
	endgenerate

	// Thermistor zone is accepted once a new code has held steadily.
	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			ts_zone <= 2'h0;
			ts_cand <= 2'h0;
			ts_cnt <= 24'h0;
		end else if (thermistor_sense_i == ts_zone) begin
			ts_cand <= ts_zone;
			ts_cnt <= 24'h0;
		end else if (thermistor_sense_i != ts_cand) begin
			ts_cand <= thermistor_sense_i;
			ts_cnt <= 24'h0;
		end else if (ts_cnt >= 24'(TS_CYC - 2)) begin
			ts_zone <= ts_cand;
			ts_cnt <= 24'h0;
		end else begin
			ts_cnt <= ts_cnt + 24'h1;
		end
	end

	wire input_good = input_voltage_present_i && !dgl[0] && !dgl[1];
	wire ts_fault = (ts_zone == `CCS_TS_FAULT_ZONE);
	wire charge_ok = input_good && !charge_enable_n_i &&
		!settings.input_disconnect_enable && !ts_fault;
	wire prechg_exp = (phase_sec >= `CCS_PRECHG_SEC);
	wire fast_exp = reached(fast_sec,
		settings.fast_charge_timer_setting);
	wire cv_exp = reached(phase_sec,
		settings.voltage_phase_timer_setting);
	wire topoff_exp = (phase_sec >= settings.finish_phase_timer_setting);
	wire wd_exp = reached(wd_sec, settings.watchdog_setting);
	wire po_hit = sec_tick &&
		reached(po_sec + 16'h1, settings.perturb_observe_interval);
	wire scan_hit = sec_tick &&
		reached(scan_sec + 16'h1, settings.panel_scan_interval);

	// Charge phase selection.
	always_comb begin
		next_phase = phase;
		unique case (phase)
			ccs_pkg::CCS_IDLE: begin
				next_phase = ccs_pkg::CCS_TRICKLE;
			end
			ccs_pkg::CCS_TRICKLE: begin
				if (battery_above_short_i) begin
					next_phase = ccs_pkg::CCS_PRECHG;
				end
			end
			ccs_pkg::CCS_PRECHG: begin
				if (prechg_exp) begin
					next_phase = ccs_pkg::CCS_FAULT;
				end else if (battery_above_low_i) begin
					next_phase = ccs_pkg::CCS_CC;
				end
			end
			ccs_pkg::CCS_CC: begin
				if (fast_exp) begin
					next_phase = ccs_pkg::CCS_FAULT;
				end else if (battery_at_regulation_i) begin
					next_phase = ccs_pkg::CCS_CV;
				end
			end
			ccs_pkg::CCS_CV: begin
				if (fast_exp || cv_exp) begin
					next_phase = ccs_pkg::CCS_FAULT;
				end else if (dgl[2]) begin
					next_phase = ccs_pkg::CCS_TOPOFF;
				end
			end
			ccs_pkg::CCS_TOPOFF: begin
				if (topoff_exp) begin
					next_phase = ccs_pkg::CCS_DONE;
				end
			end
			ccs_pkg::CCS_DONE: begin
				if (dgl[3]) begin
					next_phase = ccs_pkg::CCS_TRICKLE;
				end
			end
			ccs_pkg::CCS_FAULT: begin
				next_phase = ccs_pkg::CCS_FAULT;
			end
		endcase
		if (!charge_ok) begin
			next_phase = ccs_pkg::CCS_IDLE;
		end
	end

	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			phase <= ccs_pkg::CCS_IDLE;
			timer_fault <= 1'h0;
		end else begin
			phase <= next_phase;
			timer_fault <= (next_phase == ccs_pkg::CCS_FAULT);
		end
	end

	// Phase and fast-charge timers in seconds.
	wire fast_run = (phase == ccs_pkg::CCS_CC) || (phase == ccs_pkg::CCS_CV);

	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			phase_sec <= 16'h0;
			fast_sec <= 16'h0;
		end else begin
			if (next_phase != phase) begin
				phase_sec <= 16'h0;
			end else if (sec_tick && phase_sec != 16'hffff) begin
				phase_sec <= phase_sec + 16'h1;
			end
			if (!fast_run) begin
				fast_sec <= 16'h0;
			end else if (sec_tick && fast_sec != 16'hffff) begin
				fast_sec <= fast_sec + 16'h1;
			end
		end
	end

	// Host watchdog and settings.
	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			wd_sec <= 16'h0;
			wd_fault <= 1'h0;
			settings <= SETTINGS_DEFAULT;
		end else begin
			if (host_access_i || settings_write_i) begin
				wd_sec <= 16'h0;
			end else if (wd_exp) begin
				wd_sec <= 16'h0;
			end else if (sec_tick) begin
				wd_sec <= wd_sec + 16'h1;
			end
			if (wd_exp && !host_access_i && !settings_write_i) begin
				wd_fault <= 1'h1;
				settings <= SETTINGS_DEFAULT;
			end else begin
				if (host_access_i) begin
					wd_fault <= 1'h0;
				end
				if (settings_write_i) begin
					settings <= settings_i;
				end
			end
		end
	end

	// Power point tracking intervals.
	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			po_sec <= 16'h0;
			scan_sec <= 16'h0;
			perturb_step_o <= 1'h0;
			panel_scan_o <= 1'h0;
		end else if (!power_point_tracking_enable_i) begin
			po_sec <= 16'h0;
			scan_sec <= 16'h0;
			perturb_step_o <= 1'h0;
			panel_scan_o <= 1'h0;
		end else begin
			perturb_step_o <= po_hit;
			panel_scan_o <= scan_hit;
			if (po_hit) begin
				po_sec <= 16'h0;
			end else if (sec_tick) begin
				po_sec <= po_sec + 16'h1;
			end
			if (scan_hit) begin
				scan_sec <= 16'h0;
			end else if (sec_tick) begin
				scan_sec <= scan_sec + 16'h1;
			end
		end
	end

	// Status report and alert pulse.
	ccs_pkg::ccs_status_type status_now;
	assign status_now = '{
		phase: phase,
		input_overvoltage: dgl[0],
		input_undervoltage: dgl[1],
		thermistor_zone: ts_zone,
		timer_fault: timer_fault,
		watchdog_fault: wd_fault
	};
	wire status_change = (status_now != status_prev);

	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			status_prev <= '0;
			alert_cnt <= 24'h0;
			host_alert_n_o <= 1'h1;
		end else begin
			status_prev <= status_now;
			if (status_change) begin
				alert_cnt <= 24'(ALERT_CYC - 1);
				host_alert_n_o <= 1'h0;
			end else if (alert_cnt != 24'h0) begin
				alert_cnt <= alert_cnt - 24'h1;
			end else begin
				host_alert_n_o <= 1'h1;
			end
		end
	end

	// Indicator pins; low level means asserted.
	wire charging = (phase == ccs_pkg::CCS_TRICKLE) ||
		(phase == ccs_pkg::CCS_PRECHG) || fast_run ||
		(phase == ccs_pkg::CCS_TOPOFF);
	wire done = (phase == ccs_pkg::CCS_DONE);
	wire fault = (phase == ccs_pkg::CCS_FAULT);

	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			power_good_out_n_o <= 1'h1;
			charge_status_pin_a_n_o <= 1'h1;
			charge_status_pin_b_n_o <= 1'h1;
			charger_enable_o <= 1'h0;
			status_o <= '0;
			settings_o <= SETTINGS_DEFAULT;
		end else begin
			if (indicator_override_i) begin
				power_good_out_n_o <= indicator_level_i[0];
				charge_status_pin_a_n_o <= indicator_level_i[1];
				charge_status_pin_b_n_o <= indicator_level_i[2];
			end else begin
				power_good_out_n_o <= !input_good;
				charge_status_pin_a_n_o <= !(charging || fault);
				charge_status_pin_b_n_o <= !(done || fault);
			end
			charger_enable_o <= charging;
			status_o <= status_now;
			settings_o <= settings;
		end
	end

endmodule

// ### testbench/ccs_top_asserts.sv
`timescale 1ns/1ps
module ccs_top_asserts #(
	parameter int OV_ENTER_CYC = 8,
	parameter int OV_EXIT_CYC = 20,
	parameter int UV_ENTER_CYC = 8,
	parameter int UV_EXIT_CYC = 20,
	parameter int TERM_CYC = 16,
	parameter int RECHG_CYC = 16
) (
	// Clock and reset.
	input wire logic clk_i,
	input wire logic reset_n_i,
	// Watched inputs.
	input wire logic input_overvoltage_sense_i,
	input wire logic input_undervoltage_sense_i,
	input wire logic charge_current_low_i,
	input wire logic feedback_voltage_low_i,
	input wire logic indicator_override_i,
	input wire logic [2:0] indicator_level_i,
	// Watched outputs.
	input wire logic power_good_out_n_o,
	input wire logic charge_status_pin_a_n_o,
	input wire logic charge_status_pin_b_n_o,
	input wire logic host_alert_n_o,
	input wire logic charger_enable_o,
	input wire ccs_pkg::ccs_status_type status_o
);
	int oh, ol, uh, ul, tc, rc;
	logic bad;
	assign bad = status_o.input_overvoltage | status_o.input_undervoltage;
	// Run lengths of steady comparator levels.
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			oh <= 0;
			ol <= 0;
			uh <= 0;
			ul <= 0;
			tc <= 0;
			rc <= 0;
		end else begin
			oh <= input_overvoltage_sense_i ? oh + 1 : 0;
			ol <= input_overvoltage_sense_i ? 0 : ol + 1;
			uh <= input_undervoltage_sense_i ? uh + 1 : 0;
			ul <= input_undervoltage_sense_i ? 0 : ul + 1;
			tc <= charge_current_low_i ? tc + 1 : 0;
			rc <= feedback_voltage_low_i ? rc + 1 : 0;
		end
	end
	default clocking @(posedge clk_i); endclocking
	default disable iff (!reset_n_i);
	property p_ov_in;
		$rose(status_o.input_overvoltage) |-> $past(oh) >= OV_ENTER_CYC;
	endproperty
	a_ov_in: assert property (p_ov_in) else $error("ov early");
	property p_ov_out;
		$fell(status_o.input_overvoltage) |-> $past(ol) >= OV_EXIT_CYC;
	endproperty
	a_ov_out: assert property (p_ov_out) else $error("ov exit early");
	property p_uv_in;
		$rose(status_o.input_undervoltage) |-> $past(uh) >= UV_ENTER_CYC;
	endproperty
	a_uv_in: assert property (p_uv_in) else $error("uv early");
	property p_uv_out;
		$fell(status_o.input_undervoltage) |-> $past(ul) >= UV_EXIT_CYC;
	endproperty
	a_uv_out: assert property (p_uv_out) else $error("uv exit early");
	property p_term;
		status_o.phase == ccs_pkg::CCS_TOPOFF &&
		$past(status_o.phase) == ccs_pkg::CCS_CV |-> $past(tc, 2) >= TERM_CYC;
	endproperty
	a_term: assert property (p_term) else $error("early end");
	property p_rechg;
		status_o.phase == ccs_pkg::CCS_TRICKLE &&
		$past(status_o.phase) == ccs_pkg::CCS_DONE |-> $past(rc, 2) >= RECHG_CYC;
	endproperty
	a_rechg: assert property (p_rechg) else $error("early restart");
	property p_order;
		status_o.phase == ccs_pkg::CCS_CC && $changed(status_o.phase)
		|-> $past(status_o.phase) == ccs_pkg::CCS_PRECHG;
	endproperty
	a_order: assert property (p_order) else $error("phase order");
	property p_halt;
		bad |-> ##[0:2] !charger_enable_o;
	endproperty
	a_halt: assert property (p_halt) else $error("charging on");
	property p_pg;
		bad && !indicator_override_i && !$past(indicator_override_i)
		|-> power_good_out_n_o;
	endproperty
	a_pg: assert property (p_pg) else $error("power good low");
	property p_alert;
		status_o != $past(status_o) |-> ##[0:2] !host_alert_n_o;
	endproperty
	a_alert: assert property (p_alert) else $error("no alert");
	property p_ovr;
		$past(indicator_override_i) |-> {charge_status_pin_b_n_o,
		charge_status_pin_a_n_o, power_good_out_n_o} ==
		$past(indicator_level_i);
	endproperty
	a_ovr: assert property (p_ovr) else $error("override");
endmodule

bind ccs_top ccs_top_asserts #(
	.OV_ENTER_CYC(OV_ENTER_CYC),
	.OV_EXIT_CYC(OV_EXIT_CYC),
	.UV_ENTER_CYC(UV_ENTER_CYC),
	.UV_EXIT_CYC(UV_EXIT_CYC),
	.TERM_CYC(TERM_CYC),
	.RECHG_CYC(RECHG_CYC)
) ccs_top_asserts_inst (
	.clk_i(clk_i),
	.reset_n_i(reset_n_i),
	.input_overvoltage_sense_i(input_overvoltage_sense_i),
	.input_undervoltage_sense_i(input_undervoltage_sense_i),
	.charge_current_low_i(charge_current_low_i),
	.feedback_voltage_low_i(feedback_voltage_low_i),
	.indicator_override_i(indicator_override_i),
	.indicator_level_i(indicator_level_i),
	.power_good_out_n_o(power_good_out_n_o),
	.charge_status_pin_a_n_o(charge_status_pin_a_n_o),
	.charge_status_pin_b_n_o(charge_status_pin_b_n_o),
	.host_alert_n_o(host_alert_n_o),
	.charger_enable_o(charger_enable_o),
	.status_o(status_o)
);

// ### testbench/ccs_far_model.sv
`timescale 1ns/1ps
module ccs_far_model (
	// Clock, converter run request and battery drain request.
	input wire logic clk_i,
	input wire logic run_i,
	input wire logic drain_i,
	// Comparator results.
	output logic above_short_o,
	output logic above_low_o,
	output logic at_reg_o,
	output logic cur_low_o,
	output logic fb_low_o
);
	logic [7:0] lvl = 8'h00;
	// Battery charges while the converter runs and saturates when full.
	always @(posedge clk_i) begin
		if (drain_i) begin
			lvl <= 8'h30;
		end else if (run_i && lvl != 8'h60) begin
			lvl <= lvl + 8'h01;
		end
	end
	assign above_short_o = lvl > 8'h10;
	assign above_low_o = lvl > 8'h20;
	assign at_reg_o = lvl >= 8'h40;
	assign cur_low_o = run_i && lvl == 8'h60;
	assign fb_low_o = lvl < 8'h40;
endmodule

// ### testbench/charger_control_sequencer_tb.sv
`timescale 1ns/1ps
`include "ccs_regs.svh"
module charger_control_sequencer_tb;
	logic clk_i = 1'b0;
	logic reset_n_i = 1'b0;
	logic [1:0] sns = 2'h0;
	logic [1:0] ts = 2'h0;
	logic ce_n = 1'b1;
	logic acc = 1'b0;
	logic wr = 1'b0;
	logic ovr = 1'b0;
	logic [2:0] lvl = 3'h0;
	logic ppt = 1'b0;
	logic drain = 1'b0;
	logic vin = 1'b1;
	localparam int DGL_SHORT = 8;
	localparam int DGL_LONG = 20;
	localparam int DGL_MID = 16;
	localparam int TICK_CYC = 10;
	localparam int ALERT_LEN = 4;
	logic bs, bl, br, cl, fl, pg_n, sa_n, sb_n, al_n, en, po, sc;
	ccs_pkg::ccs_settings_type si = '0;
	ccs_pkg::ccs_settings_type so;
	ccs_pkg::ccs_status_type st;
	int miscompares = 0;
	int n_compared = 0;
	int cyc = 0;
	int k, n, pc, scn;
	logic [31:0] seed = 32'h14;

	always #10 clk_i = ~clk_i;

	ccs_top #(.OV_ENTER_CYC(DGL_SHORT), .OV_EXIT_CYC(DGL_LONG),
		.UV_ENTER_CYC(DGL_SHORT), .UV_EXIT_CYC(DGL_LONG),
		.TERM_CYC(DGL_MID), .RECHG_CYC(DGL_MID), .TS_CYC(DGL_MID),
		.MS_TICK_CYC(TICK_CYC), .ALERT_CYC(ALERT_LEN)) ccs_top_inst (
		.clk_i(clk_i),
		.reset_n_i(reset_n_i),
		.input_voltage_present_i(vin),
		.input_overvoltage_sense_i(sns[0]),
		.input_undervoltage_sense_i(sns[1]),
		.charge_current_low_i(cl),
		.feedback_voltage_low_i(fl),
		.thermistor_sense_i(ts),
		.battery_above_short_i(bs),
		.battery_above_low_i(bl),
		.battery_at_regulation_i(br),
		.charge_enable_n_i(ce_n),
		.host_access_i(acc),
		.settings_write_i(wr),
		.settings_i(si),
		.indicator_override_i(ovr),
		.indicator_level_i(lvl),
		.power_point_tracking_enable_i(ppt),
		.power_good_out_n_o(pg_n),
		.charge_status_pin_a_n_o(sa_n),
		.charge_status_pin_b_n_o(sb_n),
		.host_alert_n_o(al_n),
		.charger_enable_o(en),
		.perturb_step_o(po),
		.panel_scan_o(sc),
		.status_o(st),
		.settings_o(so)
	);

	ccs_far_model ccs_far_model_inst (
		.clk_i(clk_i),
		.run_i(en),
		.drain_i(drain),
		.above_short_o(bs),
		.above_low_o(bl),
		.at_reg_o(br),
		.cur_low_o(cl),
		.fb_low_o(fl)
	);

	function logic [31:0] xs(input logic [31:0] x);
		x ^= x << 13;
		x ^= x >> 17;
		x ^= x << 5;
		return x;
	endfunction

	function int npul(input int win, input int sec);
		return win / (sec * TICK_CYC * 1000);
	endfunction

	function logic flag(input int i);
		return i ? st.input_undervoltage : st.input_overvoltage;
	endfunction

	task wrap_up;
		$display("compared %0d mismatched %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	task chk(input logic [15:0] seen, input logic [15:0] exp);
		n_compared++;
		if (seen !== exp) begin
			miscompares++;
			$display("[FAIL] %0t seen %h exp %h", $time, seen, exp);
		end
	endtask

	task wt(input int c);
		repeat (c) @(negedge clk_i);
	endtask

	task wph(input ccs_pkg::ccs_phase_type p);
		for (k = 0; k < 400 && st.phase !== p; k++) @(negedge clk_i);
		chk(st.phase, p);
	endtask

	task pls(input logic w);
		wr = w;
		acc = !w;
		@(negedge clk_i);
		wr = 1'b0;
		acc = 1'b0;
	endtask

	always @(posedge clk_i) begin
		cyc <= cyc + 1;
		if (cyc == 70000) begin
			miscompares++;
			wrap_up;
		end
	end

	initial begin
		si = '{16'h0064, 16'h0000, 16'h0064, 16'h0001, 16'h0002,
			16'h0000, 1'b0};
		wt(12);
		chk({sa_n, sb_n, pg_n, al_n, en}, 5'h1e);
		reset_n_i = 1'b1;
		wt(3);
		ce_n = 1'b0;
		pls(1'b1);
		wt(1);
		chk(so.fast_charge_timer_setting, 16'h0064);
		wph(ccs_pkg::CCS_TRICKLE);
		wph(ccs_pkg::CCS_PRECHG);
		wph(ccs_pkg::CCS_CC);
		chk(en, 1'b1);
		chk({sa_n, sb_n}, 2'h1);
		wph(ccs_pkg::CCS_CV);
		wph(ccs_pkg::CCS_DONE);
		chk({sa_n, sb_n}, 2'h2);
		drain = 1'b1;
		wt(1);
		drain = 1'b0;
		wph(ccs_pkg::CCS_TRICKLE);
		for (n = 0; n < 2; n++) begin
			seed = xs(seed);
			sns[n] = 1'b1;
			wt(seed % 7 + 1);
			sns[n] = 1'b0;
			wt(3);
			chk(flag(n), 1'b0);
			sns[n] = 1'b1;
			wt(14);
			chk(flag(n), 1'b1);
			chk({pg_n, en}, 2'h2);
			sns[n] = 1'b0;
			wt(12);
			chk(flag(n), 1'b1);
			wt(12);
			chk(flag(n), 1'b0);
			chk(pg_n, 1'b0);
		end
		for (n = 0; n < 8; n++) begin
			ovr = 1'b1;
			lvl = n[2:0];
			wt(2);
			chk({sb_n, sa_n, pg_n}, lvl);
		end
		ovr = 1'b0;
		vin = 1'b0;
		wt(4);
		chk({pg_n, en}, 2'h2);
		vin = 1'b1;
		wt(2);
		chk(pg_n, 1'b0);
		ppt = 1'b1;
		pc = 0;
		scn = 0;
		for (n = 0; n < 25000; n++) begin
			@(negedge clk_i);
			pc += po;
			scn += sc;
			if (n % 5000 == 4999) begin
				chk(st.thermistor_zone, ts);
				seed = xs(seed);
				ts = 2'(seed % 3);
			end
		end
		chk(pc, npul(25000, 1));
		chk(scn, npul(25000, 2));
		ts = `CCS_TS_FAULT_ZONE;
		wt(24);
		chk(st.thermistor_zone, `CCS_TS_FAULT_ZONE);
		chk(en, 1'b0);
		ts = 2'h0;
		ppt = 1'b0;
		si.watchdog_setting = 16'h0002;
		pls(1'b1);
		wt(9000);
		chk(st.watchdog_fault, 1'b0);
		pls(1'b0);
		wt(9000);
		chk(st.watchdog_fault, 1'b0);
		for (k = 0; k < 12000 && st.watchdog_fault !== 1'b1; k++) wt(1);
		chk(st.watchdog_fault, 1'b1);
		chk(so.watchdog_setting, `CCS_WDOG_DEF_SEC);
		pls(1'b0);
		wt(2);
		chk(st.watchdog_fault, 1'b0);
		wrap_up;
	end
endmodule
